// ===== src/lat_table_regs.svh
/*
  Constants of the latency-table map: byte values, map layout, row
  contents, link timing. Assumes inclusion by bare name from src/.
*/
`ifndef LAT_TABLE_REGS_SVH
`define LAT_TABLE_REGS_SVH

// ==========================================================
// parameter identifiers, lengths and header bytes
`define FILL 8'hff
`define PAD_ID 8'hf0
`define PAD_LEN 8'h0f
`define DDR_ID 8'h9a
`define DDR_LEN 8'h2a
`define DDR_ROWS 8'h05
`define DDR_ROW_BYTES 8'h08
`define HDR_FREQ 8'h46
`define HDR_CODE 8'h43
`define CMD_FAST_3B 8'h0d
`define CMD_FAST_4B 8'h0e
`define CMD_DUAL_3B 8'hbd
`define CMD_DUAL_4B 8'hbe
`define CMD_QUAD_3B 8'hed
`define CMD_QUAD_4B 8'hee

// ==========================================================
// map layout, byte addresses on the link
`define MAP_PAD_BASE 8'h00
`define MAP_DDR_BASE 8'h11
`define MAP_SDR_TAIL 8'h3d
`define SDR_TAIL_BYTES 8'h06
`define ROW_FIRST_OFS 8'h0c

// ==========================================================
// rows: freq, code, fast m/d, dual m/d, quad m/d
`define ROW_LC11 64'h3203_0401_0202_0103
`define ROW_LC00 64'h4200_0402_0204_0106
`define ROW_LC01 64'h4201_0404_0205_0107
`define ROW_LC10 64'h4202_0405_0206_0108

// ==========================================================
// configuration field and link timing
`define CFG_LC_HI 7
`define CFG_LC_LO 6
`define CLK_PERIOD_NS 20
`define CLK_MHZ 50
`define SCK_HALF_NS 80
`define SCK_HALF_CYC ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_SCK_MHZ (`CLK_MHZ / (2 * `SCK_HALF_CYC))
`define FLUSH_PULSES 4'h2
`define COUNT_LAST 3'h5

`endif

// ===== src/lat_table_pkg.sv
/*
  Types shared by both ends of the latency-table link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lat_table_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [63:0] row_word_t;
  // [5] fast mode .. [0] quad dummy
  typedef logic [5:0][7:0] cyc_counts_t;
  typedef enum logic [1:0] {C_FLUSH, C_IDLE, C_SHIFT} ctrl_state_t;
  typedef enum logic [2:0] {
    W_IDLE, W_ID, W_LEN, W_FREQ, W_CODE, W_CNT
  } walk_state_t;
endpackage

// ===== src/spi_link_if.sv
/*
  Serial link between host controller and flash map.
  Assumes the host end makes sck; the flash end is clocked by it.
*/
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  modport flash (input sck, input cs_n, input si, output so);
  modport ctrl (output sck, output cs_n, output si, input so);
endinterface
`default_nettype wire

// ===== src/flash_lat_map.sv
/*
  Flash end: read-only parameter map served over the serial link,
  plus the mode/dummy counts of the row chosen by the latency code.
  Assumes frames of exactly 16 sck periods: 8 address bits in on
  rising edges, 8 data bits out, changed on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lat_table_regs.svh"
module flash_lat_map (
  spi_link_if.flash link, // link, flash end
  input wire logic nrst_i, // reset, active low, on sck
  input wire logic [7:0] cfg_i, // non-volatile configuration byte
  output logic [7:0] freq_limit_o, // active row sck ceiling, mhz
  output lat_table_pkg::cyc_counts_t counts_o // active row counts
);
  import lat_table_pkg::*;

  logic [3:0] cnt_q;
  byte_t addr_q;
  byte_t sh_q;
  logic so_q;
  logic [1:0] lc_s1_q;
  logic [1:0] lc_s2_q;
  row_word_t act_row;

  // ==========================================================
  // table contents
  function automatic row_word_t row_of(input logic [1:0] code);
    row_word_t w;
    w = `ROW_LC00;
    case (code)
      2'h3: w = `ROW_LC11;
      2'h0: w = `ROW_LC00;
      2'h1: w = `ROW_LC01;
      2'h2: w = `ROW_LC10;
      default: w = `ROW_LC00;
    endcase
    return w;
  endfunction

  function automatic byte_t ddr_byte(input byte_t o);
    byte_t r;
    byte_t k;
    row_word_t w;
    r = `FILL;
    k = o - `ROW_FIRST_OFS;
    w = row_of(k[4:3] - 2'h1) << {k[2:0], 3'h0};
    case (o)
      8'h00: r = `DDR_ID;
      8'h01: r = `DDR_LEN;
      8'h02: r = `DDR_ROWS;
      8'h03: r = `DDR_ROW_BYTES;
      8'h04: r = `HDR_FREQ;
      8'h05: r = `HDR_CODE;
      8'h06: r = `CMD_FAST_3B;
      8'h07: r = `CMD_FAST_4B;
      8'h08: r = `CMD_DUAL_3B;
      8'h09: r = `CMD_DUAL_4B;
      8'h0a: r = `CMD_QUAD_3B;
      8'h0b: r = `CMD_QUAD_4B;
      default: begin
        // rows 2..5 in the order 11b, 00b, 01b, 10b
        r = w[63:56];
      end
    endcase
    return r;
  endfunction

  function automatic byte_t map_byte(input byte_t a);
    byte_t r;
    r = `FILL;
    if (a == `MAP_PAD_BASE) begin
      r = `PAD_ID;
    end else if (a == `MAP_PAD_BASE + 8'h01) begin
      r = `PAD_LEN;
    end else if (a < `MAP_DDR_BASE) begin
      r = `FILL;
    end else if (a <= `MAP_DDR_BASE + `DDR_LEN + 8'h01) begin
      r = ddr_byte(a - `MAP_DDR_BASE);
    end else if (a < `MAP_SDR_TAIL + `SDR_TAIL_BYTES) begin
      // unsupported sdr entries read as all ones
      r = `FILL;
    end else begin
      r = `FILL;
    end
    return r;
  endfunction

  // ==========================================================
  // frame bit counter
  // sck only runs inside frames and in the reset flush, so a frame must end on a count of
  // 16 edges; cs_n high at any edge also brings the counter home
  always_ff @(posedge link.sck) begin
    if (!nrst_i || link.cs_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // address in, msb first
  always_ff @(posedge link.sck) begin
    if (!nrst_i) begin
      addr_q <= 8'h00;
    end else if (!link.cs_n && !cnt_q[3]) begin
      addr_q <= {addr_q[6:0], link.si};
    end
  end

  // ==========================================================
  // data out: loaded on the eighth rising edge, shifted after
  always_ff @(posedge link.sck) begin
    if (!nrst_i) begin
      sh_q <= 8'h00;
    end else if (!link.cs_n && cnt_q == 4'h7) begin
      sh_q <= map_byte({addr_q[6:0], link.si});
    end else if (!link.cs_n && cnt_q[3]) begin
      sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  // changed on the falling edge so the host has a full half period
  always_ff @(negedge link.sck) begin
    if (!nrst_i || link.cs_n) begin
      so_q <= 1'b0;
    end else if (cnt_q[3]) begin
      so_q <= sh_q[7];
    end
  end

  assign link.so = so_q;

  // ==========================================================
  // latency code selection
  // the configuration byte is foreign to sck, so it is brought over
  // by two flops; it only settles once frames are running
  always_ff @(posedge link.sck) begin
    if (!nrst_i) begin
      lc_s1_q <= 2'h0;
      lc_s2_q <= 2'h0;
    end else begin
      lc_s1_q <= {cfg_i[`CFG_LC_HI], cfg_i[`CFG_LC_LO]};
      lc_s2_q <= lc_s1_q;
    end
  end

  assign act_row = row_of(lc_s2_q);

  always_ff @(posedge link.sck) begin
    if (!nrst_i) begin
      freq_limit_o <= 8'h00;
      counts_o <= '0;
    end else begin
      freq_limit_o <= act_row[63:56];
      counts_o <= act_row[47:0];
    end
  end

endmodule
`default_nettype wire

// ===== src/spi_map_host.sv
/*
  Host end: makes sck from clock_i, reads single map bytes for the
  user, and walks the map to fetch the row of a latency code.
  Assumes the flash end answers as in flash_lat_map.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lat_table_regs.svh"
module spi_map_host (
  input wire logic clock_i, // 50 mhz system clock
  input wire logic nrst_i, // synchronous reset, active low
  spi_link_if.ctrl link, // link, host end
  input wire logic rd_start_i, // read one byte request
  input wire logic [7:0] rd_addr_i, // byte address to read
  output logic rd_ready_o, // request will be taken
  output logic rd_done_o, // read finished, one cycle
  output logic [7:0] rd_data_o, // byte read
  input wire logic walk_start_i, // walk the map request
  input wire logic [1:0] walk_code_i, // latency code to look up
  output logic walk_busy_o, // walk under way
  output logic walk_done_o, // walk finished, one cycle
  output logic walk_err_o, // last walk failed
  output logic [7:0] walk_freq_o, // row sck ceiling, mhz
  output lat_table_pkg::cyc_counts_t walk_counts_o, // row counts
  output logic [2:0] walk_supported_o, // fast, dual, quad usable
  output logic walk_freq_ok_o // row ceiling covers our sck
);
  import lat_table_pkg::*;

  ctrl_state_t cst_q;
  walk_state_t wst_q;
  logic [2:0] div_q;
  logic [3:0] bit_q;
  logic sck_q, csn_q, tick, so_s1_q, so_s2_q;
  logic eng_done_q, user_q, pend_q, wreq, ustart, wdone;
  byte_t tx_q, rx_q, wa_q, id_q;
  logic [1:0] code_q, row_q;
  logic [2:0] idx_q;
  logic [8:0] nxt;

  // ==========================================================
  // link engine
  assign tick = div_q == 3'(`SCK_HALF_CYC - 1);
  assign ustart = rd_start_i && rd_ready_o;
  assign wreq = pend_q && cst_q == C_IDLE;
  assign rd_ready_o = cst_q == C_IDLE && wst_q == W_IDLE;
  assign link.sck = sck_q;
  assign link.cs_n = csn_q;
  assign link.si = tx_q[7];
  assign rd_data_o = rx_q;
  assign rd_done_o = eng_done_q && user_q;
  assign wdone = eng_done_q && !user_q;

  always_ff @(posedge clock_i) begin
    if (!nrst_i || cst_q == C_IDLE || tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // after reset, idle pulses with cs_n high home the flash counter
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cst_q <= C_FLUSH;
      sck_q <= 1'b0;
      csn_q <= 1'b1;
      bit_q <= 4'h0;
    end else begin
      case (cst_q)
        C_FLUSH: begin
          if (tick) begin
            sck_q <= ~sck_q;
            if (sck_q) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == `FLUSH_PULSES - 4'h1) begin
                cst_q <= C_IDLE;
              end
            end
          end
        end
        C_IDLE: begin
          if (wreq || ustart) begin
            csn_q <= 1'b0;
            bit_q <= 4'h0;
            cst_q <= C_SHIFT;
          end
        end
        default: begin
          if (tick) begin
            sck_q <= ~sck_q;
            if (sck_q) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'hf) begin
                csn_q <= 1'b1;
                cst_q <= C_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      tx_q <= 8'h00;
      user_q <= 1'b0;
    end else if (cst_q == C_IDLE && (wreq || ustart)) begin
      tx_q <= wreq ? wa_q : rd_addr_i;
      user_q <= ustart;
    end else if (cst_q == C_SHIFT && tick && sck_q) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // so changes on falling sck; a half period of 4 cycles leaves room
  // for the two-flop delay before the next rising edge samples it
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      so_s1_q <= 1'b0;
      so_s2_q <= 1'b0;
      rx_q <= 8'h00;
      eng_done_q <= 1'b0;
    end else begin
      so_s1_q <= link.so;
      so_s2_q <= so_s1_q;
      if (cst_q == C_SHIFT && tick && !sck_q && bit_q[3]) begin
        rx_q <= {rx_q[6:0], so_s2_q};
      end
      eng_done_q <= cst_q == C_SHIFT && tick && sck_q && bit_q == 4'hf;
    end
  end

  // ==========================================================
  // map walker
  assign nxt = {1'b0, wa_q} + {1'b0, rx_q} + 9'h001;
  assign walk_busy_o = wst_q != W_IDLE;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      walk_supported_o[2 - i] = walk_counts_o[5 - 2 * i] != `FILL &&
        walk_counts_o[4 - 2 * i] != `FILL;
    end
  end
  assign walk_freq_ok_o = walk_freq_o >= 8'(`HOST_SCK_MHZ);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wst_q <= W_IDLE;
      pend_q <= 1'b0;
      walk_done_o <= 1'b0;
      walk_err_o <= 1'b0;
      wa_q <= 8'h00;
      id_q <= 8'h00;
      code_q <= 2'h0;
      row_q <= 2'h0;
      idx_q <= 3'h0;
      walk_freq_o <= 8'h00;
      walk_counts_o <= '0;
    end else begin
      walk_done_o <= 1'b0;
      if (wreq) begin
        pend_q <= 1'b0;
      end
      case (wst_q)
        W_IDLE: begin
          if (walk_start_i && !ustart) begin
            wa_q <= `MAP_PAD_BASE;
            code_q <= walk_code_i;
            walk_err_o <= 1'b0;
            pend_q <= 1'b1;
            wst_q <= W_ID;
          end
        end
        W_ID: begin
          if (wdone && rx_q == `FILL) begin
            walk_err_o <= 1'b1;
            walk_done_o <= 1'b1;
            wst_q <= W_IDLE;
          end else if (wdone) begin
            id_q <= rx_q;
            wa_q <= wa_q + 8'h01;
            pend_q <= 1'b1;
            wst_q <= W_LEN;
          end
        end
        W_LEN: begin
          if (wdone && id_q == `DDR_ID) begin
            wa_q <= wa_q + `ROW_FIRST_OFS - 8'h01;
            row_q <= 2'h0;
            pend_q <= 1'b1;
            wst_q <= W_FREQ;
          end else if (wdone && nxt[8]) begin
            walk_err_o <= 1'b1;
            walk_done_o <= 1'b1;
            wst_q <= W_IDLE;
          end else if (wdone) begin
            wa_q <= nxt[7:0];
            pend_q <= 1'b1;
            wst_q <= W_ID;
          end
        end
        W_FREQ: begin
          if (wdone) begin
            walk_freq_o <= rx_q;
            wa_q <= wa_q + 8'h01;
            pend_q <= 1'b1;
            wst_q <= W_CODE;
          end
        end
        W_CODE: begin
          if (wdone && rx_q == {6'h00, code_q}) begin
            wa_q <= wa_q + 8'h01;
            idx_q <= 3'h0;
            pend_q <= 1'b1;
            wst_q <= W_CNT;
          end else if (wdone && row_q == 2'h3) begin
            walk_err_o <= 1'b1;
            walk_done_o <= 1'b1;
            wst_q <= W_IDLE;
          end else if (wdone) begin
            row_q <= row_q + 2'h1;
            wa_q <= wa_q + `DDR_ROW_BYTES - 8'h01;
            pend_q <= 1'b1;
            wst_q <= W_FREQ;
          end
        end
        default: begin
          if (wdone) begin
            walk_counts_o[3'h5 - idx_q] <= rx_q;
            if (idx_q == `COUNT_LAST) begin
              walk_done_o <= 1'b1;
              wst_q <= W_IDLE;
            end else begin
              idx_q <= idx_q + 3'h1;
              wa_q <= wa_q + 8'h01;
              pend_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== testbench/lat_exp_pkg.sv
/*
  Expected map bytes and row lookup for the bench side.
  Assumes the flash end's chosen layout: padding at 00h, ddr at 11h.
*/
`default_nettype none
package lat_exp_pkg;
  // ==========================================================
  // ddr parameter, bytes counted from its base
  localparam logic [7:0] DDR_MAP [0:43] = '{
    8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43,
    8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee,
    8'h32, 8'h03, 8'h04, 8'h01, 8'h02, 8'h02, 8'h01, 8'h03,
    8'h42, 8'h00, 8'h04, 8'h02, 8'h02, 8'h04, 8'h01, 8'h06,
    8'h42, 8'h01, 8'h04, 8'h04, 8'h02, 8'h05, 8'h01, 8'h07,
    8'h42, 8'h02, 8'h04, 8'h05, 8'h02, 8'h06, 8'h01, 8'h08
  };

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    if (a == 8'h00) return 8'hf0;
    if (a == 8'h01) return 8'h0f;
    if (a >= 8'h11 && a <= 8'h3c) return DDR_MAP[a - 8'h11];
    return 8'hff;
  endfunction

  // ==========================================================
  // row of a code as {freq, six counts}, all ones if absent
  function automatic logic [55:0] exp_row(input logic [1:0] code);
    logic [55:0] r;
    r = '1;
    for (int k = 0; k < 4; k++)
      if (DDR_MAP[13 + 8 * k] == {6'h00, code})
        for (int j = 0; j < 7; j++)
          r[55 - 8 * j -: 8] = DDR_MAP[12 + 8 * k + ((j == 0) ? 0 : j + 1)];
    return r;
  endfunction
endpackage
`default_nettype wire

// ===== testbench/lat_table_chk_chk.sv
/*
  Checker on the serial link: rebuilds each frame's address and data
  byte and holds the byte against the map.
  Assumes frames of 16 sck rises, sck made from clock_i.
*/
`timescale 1ns/1ns
`default_nettype none
module lat_table_chk
  import lat_exp_pkg::*;
(
  input wire logic clock_i, // host clock
  input wire logic nrst_i, // reset, active low
  input wire logic sck, // link clock
  input wire logic cs_n, // frame select
  input wire logic si, // host to flash
  input wire logic so // flash to host
);
  logic sck_q;
  logic cs_q;
  logic [4:0] bits_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;

  // ==========================================================
  // frame rebuild
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sck_q <= sck;
      cs_q <= cs_n;
    end
  end

  // so is read a cycle after the rise, long after its falling change
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      bits_q <= 5'h00;
      addr_q <= 8'h00;
      data_q <= 8'h00;
    end else if (!cs_n && cs_q) begin
      bits_q <= 5'h00;
    end else if (!cs_n && sck && !sck_q) begin
      bits_q <= bits_q + 5'h01;
      if (bits_q < 5'h08) addr_q <= {addr_q[6:0], si};
      else data_q <= {data_q[6:0], so};
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_byte_in(logic [7:0] lo, logic [7:0] hi);
    $rose(cs_n) && bits_q == 5'h10 && addr_q >= lo && addr_q <= hi;
  endsequence

  property p_ddr_head;
    s_byte_in(8'h11, 8'h14) |-> data_q == exp_byte(addr_q);
  endproperty
  a_ddr_head: assert property (p_ddr_head)
    else $error("ddr parameter head byte wrong");
  property p_ddr_len;
    s_byte_in(8'h12, 8'h12) |-> data_q == 8'h2a;
  endproperty
  a_ddr_len: assert property (p_ddr_len)
    else $error("ddr parameter length wrong");
  property p_hdr_fc;
    s_byte_in(8'h15, 8'h16) |-> data_q == (addr_q[0] ? 8'h46 : 8'h43);
  endproperty
  a_hdr_fc: assert property (p_hdr_fc)
    else $error("header column marks wrong");
  property p_fast_codes;
    s_byte_in(8'h17, 8'h18) |-> data_q == (addr_q[0] ? 8'h0d : 8'h0e);
  endproperty
  a_fast_codes: assert property (p_fast_codes)
    else $error("fast ddr codes wrong");
  property p_dual_codes;
    s_byte_in(8'h19, 8'h1a) |-> data_q == (addr_q[0] ? 8'hbd : 8'hbe);
  endproperty
  a_dual_codes: assert property (p_dual_codes)
    else $error("dual ddr codes wrong");
  property p_quad_codes;
    s_byte_in(8'h1b, 8'h1c) |-> data_q == (addr_q[0] ? 8'hed : 8'hee);
  endproperty
  a_quad_codes: assert property (p_quad_codes)
    else $error("quad ddr codes wrong");
  property p_row(logic [7:0] lo);
    s_byte_in(lo, lo + 8'h07) |-> data_q == DDR_MAP[addr_q - 8'h11];
  endproperty
  a_row_11: assert property (p_row(8'h1d))
    else $error("row of code 11 wrong");
  a_row_00: assert property (p_row(8'h25))
    else $error("row of code 00 wrong");
  a_row_01: assert property (p_row(8'h2d))
    else $error("row of code 01 wrong");
  a_row_10: assert property (p_row(8'h35))
    else $error("row of code 10 wrong");
  property p_sdr_tail;
    s_byte_in(8'h3d, 8'h42) |-> data_q == 8'hff;
  endproperty
  a_sdr_tail: assert property (p_sdr_tail)
    else $error("single rate tail not all ones");
  property p_pad;
    s_byte_in(8'h00, 8'h10) |-> data_q == exp_byte(addr_q);
  endproperty
  a_pad: assert property (p_pad)
    else $error("padding parameter byte wrong");
endmodule
`default_nettype wire

// ===== testbench/tb.sv
/*
  Bench joining host and flash ends over one link; reads the map,
  walks it per code and checks the flash's own row outputs.
  Assumes the hand-over timing of the host end.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lat_table_pkg::*;
  import lat_exp_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rd_start_i, rd_ready_o, rd_done_o, walk_start_i, walk_busy_o;
  logic walk_done_o, walk_err_o, walk_freq_ok_o;
  logic [7:0] rd_addr_i, rd_data_o, walk_freq_o, cfg_i, freq_limit_o;
  logic [1:0] walk_code_i;
  logic [2:0] walk_supported_o;
  cyc_counts_t walk_counts_o, counts_o;
  int n_mismatch = 0;
  int compares = 0;
  integer seed = 32'h391d9c5f;
  byte_t exp_rd[$];
  logic [60:0] exp_walk[$];

  always #10 clock_i = ~clock_i;

  spi_link_if link();
  spi_map_host i_spi_map_host(.clock_i(clock_i), .nrst_i(nrst_i),
    .link(link), .rd_start_i(rd_start_i), .rd_addr_i(rd_addr_i),
    .rd_ready_o(rd_ready_o), .rd_done_o(rd_done_o), .rd_data_o(rd_data_o),
    .walk_start_i(walk_start_i), .walk_code_i(walk_code_i),
    .walk_busy_o(walk_busy_o), .walk_done_o(walk_done_o),
    .walk_err_o(walk_err_o), .walk_freq_o(walk_freq_o),
    .walk_counts_o(walk_counts_o), .walk_supported_o(walk_supported_o),
    .walk_freq_ok_o(walk_freq_ok_o));
  flash_lat_map i_flash_lat_map(.link(link), .nrst_i(nrst_i),
    .cfg_i(cfg_i), .freq_limit_o(freq_limit_o), .counts_o(counts_o));
  lat_table_chk i_lat_table_chk(.clock_i(clock_i), .nrst_i(nrst_i),
    .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so(link.so));

  // ==========================================================
  // reporting
  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic expire(input string what);
    n_mismatch++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    end_sim;
  endtask

  task automatic drain;
    for (int i = 0; i < 6000; i++) begin
      if (exp_rd.size() == 0 && exp_walk.size() == 0) return;
      @(negedge clock_i);
    end
    expire("drain");
  endtask

  // ==========================================================
  // drivers, entered at a falling edge
  task automatic rd(input byte_t a);
    int i;
    for (i = 0; i < 400 && rd_ready_o !== 1'b1; i++) @(negedge clock_i);
    if (i == 400) expire("rd_ready_o");
    rd_start_i = 1'b1;
    rd_addr_i = a;
    exp_rd.push_back(exp_byte(a));
    @(negedge clock_i);
    rd_start_i = 1'b0;
  endtask

  task automatic walk(input logic [1:0] c);
    logic [55:0] r;
    logic [2:0] sup;
    int i;
    r = exp_row(c);
    // a pair holding all ones marks that read form unusable
    for (i = 0; i < 3; i++) begin
      sup[2 - i] = r[47 - 16 * i -: 8] != 8'hff &&
        r[39 - 16 * i -: 8] != 8'hff;
    end
    for (i = 0; i < 400 && rd_ready_o !== 1'b1; i++) @(negedge clock_i);
    if (i == 400) expire("rd_ready_o");
    walk_start_i = 1'b1;
    walk_code_i = c;
    exp_walk.push_back({1'b0, sup, r[55:48] >= 8'h06, r});
    @(negedge clock_i);
    walk_start_i = 1'b0;
    check("walk_busy_o", 64'h1, 64'(walk_busy_o));
    // reads asked for mid-walk must be dropped without a trace
    for (i = 0; i < 8; i++) begin
      check("rd_ready_o", 64'h0, 64'(rd_ready_o));
      rd_start_i = (rd_ready_o === 1'b0);
      rd_addr_i = byte_t'($random(seed));
      @(negedge clock_i);
    end
    rd_start_i = 1'b0;
    drain;
  endtask

  // ==========================================================
  // result watcher
  always @(negedge clock_i) begin
    if (rd_done_o === 1'b1) begin
      if (exp_rd.size() == 0) check("rd_done_o", 64'h0, 64'h1);
      else check("rd_data_o", exp_rd.pop_front(), rd_data_o);
    end
    if (walk_done_o === 1'b1) begin
      if (exp_walk.size() == 0) check("walk_done_o", 64'h0, 64'h1);
      else check("walk", exp_walk.pop_front(), {walk_err_o,
        walk_supported_o, walk_freq_ok_o, walk_freq_o, walk_counts_o});
      check("walk_busy_o", 64'h0, 64'(walk_busy_o));
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [55:0] r;
    rd_start_i = 1'b0;
    rd_addr_i = 8'h00;
    walk_start_i = 1'b0;
    walk_code_i = 2'h0;
    cfg_i = 8'h00;
    repeat (4) @(negedge clock_i);
    nrst_i = 1'b1;
    for (int a = 0; a < 'h50; a++) rd(a[7:0]);
    drain;
    $display("test map sweep done");
    repeat (16) rd(byte_t'($random(seed)));
    drain;
    $display("test random reads done");
    for (int c = 3; c >= 0; c--) walk(c[1:0]);
    $display("test walks done");
    for (int c = 0; c < 4; c++) begin
      cfg_i = {c[1:0], 6'($random(seed))};
      r = exp_row(c[1:0]);
      rd(8'h11);
      rd(8'h3d);
      drain;
      check("freq_limit_o", 64'(r[55:48]), 64'(freq_limit_o));
      check("counts_o", 64'(r[47:0]), 64'(counts_o));
    end
    $display("test flash row select done");
    rd(8'h15);
    repeat (40) @(negedge clock_i);
    nrst_i = 1'b0;
    exp_rd.delete();
    repeat (4) @(negedge clock_i);
    nrst_i = 1'b1;
    rd(8'h16);
    rd(8'h2d);
    drain;
    $display("test reset mid read done");
    end_sim;
  end
endmodule
`default_nettype wire
